// ---- gpec_pkg.sv ----
/*
 * Constants, register map, field positions and state encoding for the
 * gated pulse event counter.
 * Assumes a 50 MHz bus clock and a 32-bit AHB-Lite register slave.
 */
`default_nettype none
package gpec_pkg;
    // ------------------------------------------------------------------
    // clock and gate timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned GATE_UNIT_NS  = 3906300;               // 3.9063 ms unit count
    localparam int unsigned GATE_UNIT_CYC = GATE_UNIT_NS / CLK_PERIOD_NS;
    localparam int unsigned UNIT_W        = 18;
    localparam logic [1:0]  ARM_LAST      = 2'h1;                  // two cycles of restart delay
    localparam logic [1:0]  FILT_LAST     = 2'h2;                  // three stable cycles to pass
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO    = 16'h0000;

    // ------------------------------------------------------------------
    // register map, byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_TIM   = 8'h04;
    localparam logic [7:0] OFS_RES_H = 8'h08;
    localparam logic [7:0] OFS_RES_L = 8'h0C;

    // control and status fields
    localparam int unsigned BIT_CEN  = 7;
    localparam int unsigned BIT_DIE  = 6;
    localparam int unsigned BIT_WIE  = 5;
    localparam int unsigned BIT_DF   = 4;
    localparam int unsigned BIT_WF   = 3;
    localparam int unsigned BIT_DCLR = 2;
    localparam int unsigned BIT_WCLR = 1;
    localparam int unsigned MEAS_LSB  = 0;
    localparam int unsigned PAUSE_LSB = 4;
    localparam logic [7:0] TIM_RST   = 8'h00;

    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARM   = 4'b0010,
        ST_MEAS  = 4'b0100,
        ST_PAUSE = 4'b1000
    } gpec_state_e;
endpackage
`default_nettype wire

// ---- gpec_evt_if.sv ----
/*
 * Carrier between the counter core and its spike filter.
 * Assumes both ends share hclk.
 */
`timescale 1ns/10ps
`default_nettype none
interface gpec_evt_if;
    logic gated_in;   // pulse pin anded with internal gate
    logic event_p;    // one cycle per filtered rising edge
    modport core (output gated_in, input event_p);
    modport filt (input gated_in, output event_p);
endinterface
`default_nettype wire

// ---- gpec_spike_filter.sv ----
/*
 * Spike filter and rising edge detector for the gated pulse.
 * Assumes gated_in is already synchronous to hclk.
 */
`timescale 1ns/10ps
`default_nettype none
module gpec_spike_filter (
    input  wire logic      hclk,     // bus clock
    input  wire logic      hresetn,  // async reset, low
    gpec_evt_if.filt       evt       // gated pulse in, event out
);
    logic       filt_q;
    logic [1:0] run_q;
    logic       ev_q;

    assign evt.event_p = ev_q;

    // ------------------------------------------------------------------
    // filter: a level must hold three cycles before it passes
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filt_q <= 1'b0;
            run_q  <= 2'h0;
            ev_q   <= 1'b0;
        end else begin
            ev_q <= 1'b0;
            if (evt.gated_in == filt_q) begin
                run_q <= 2'h0;
            end else if (run_q == gpec_pkg::FILT_LAST) begin
                run_q  <= 2'h0;
                filt_q <= evt.gated_in;
                ev_q   <= evt.gated_in;
            end else begin
                run_q <= run_q + 2'h1;
            end
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_spike_blocked: assert property (ev_q |-> $past(evt.gated_in, 1) && $past(evt.gated_in, 2)
                                      && $past(evt.gated_in, 3))
        else $error("event passed from a pulse shorter than three cycles");
endmodule
`default_nettype wire

// ---- gpec_counter.sv ----
/*
 * Gated pulse event counter with AHB-Lite register slave.
 * Assumes one AHB-Lite master, single word transfers, pulse pin asynchronous.
 */
// Operation
// - with count enable set, measurements repeat with the gate low time between them; clearing it stops.
// - writing the timing register aborts the measurement and restarts with new values.
// - low timing nibble times unit count sets gate high time.
// - high timing nibble times unit count sets gate low time.
// - counter input is pulse pin anded with internal gate.
// - each rising edge of gated input adds one to the count.
// - spike filter drops gated pulses too narrow to detect.
// - after a timing write, gate rises on the fourth cycle of that write.
// - result cleared at internal gate rise; external gate rises two cycles later.
// - gate high starts on setting count enable, on timing write or when wait time expires.
// - every window keeps the same length until timing register changes.
// - done flag set at falling edge of gate.
// - writing one to done clear strobe clears done flag; strobe reads zero.
// - writing one to wrap clear strobe clears wrap flag; strobe reads zero.
// - both flags clear at the start of every measurement.
// - count past 65535 sets wrap flag and continues from zero.
// - wrap interrupt only when wrap flag and its enable are set.
// - done interrupt only when done flag and its enable are set.
// - counter runs in wait mode; enabled interrupts wake the processor.
// - in stop mode the counter is disabled.
// - while gate is low, result holds last completed count.
`timescale 1ns/10ps
`default_nettype none
module gpec_counter #(
    parameter int unsigned UNIT_CYCLES = gpec_pkg::GATE_UNIT_CYC  // cycles per gate unit
) (
    input  wire logic        hclk,             // bus clock, 50 MHz
    input  wire logic        hresetn,          // async reset, low
    input  wire logic        hsel,             // slave select
    input  wire logic [31:0] haddr,            // byte address
    input  wire logic [1:0]  htrans,           // transfer type
    input  wire logic        hwrite,           // write when high
    input  wire logic [2:0]  hsize,            // transfer size
    input  wire logic [31:0] hwdata,           // write data
    input  wire logic        hready,           // bus ready
    output logic             hreadyout,        // slave ready
    output logic             hresp,            // always okay
    output logic [31:0]      hrdata,           // read data
    input  wire logic        pulse_input_pin,  // external pulse source
    input  wire logic        stop_mode,        // processor in stop mode
    output logic             gate_out,         // external gate
    output logic             count_done_irq,   // done interrupt request
    output logic             wrap_irq,         // wrap interrupt request
    output logic             wake_req          // wakeup from wait mode
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    gpec_pkg::gpec_state_e state_q;
    logic [1:0]              arm_q;
    logic [gpec_pkg::UNIT_W-1:0] unit_q;
    logic [3:0]              step_q;
    logic [7:0]              timing_q;
    logic                    count_enable_q;
    logic                    done_irq_enable_q;
    logic                    wrap_irq_enable_q;
    logic                    done_flag_q;
    logic                    wrap_flag_q;
    logic [15:0]             count_q;
    logic                    pin_s1_q;
    logic                    pin_s2_q;
    logic                    gate_d1_q;
    logic                    gate_out_q;
    logic                    done_irq_q;
    logic                    wrap_irq_q;
    logic                    wake_q;
    logic                    wr_pend_q;
    logic [7:0]              addr_q;
    logic [31:0]             hrdata_q;
    logic                    hreadyout_q;
    logic                    hresp_q;

    logic       run;
    logic       gate_int;
    logic       ctrl_wr;
    logic       tim_wr;
    logic       unit_last;
    logic [3:0] meas_nib;
    logic [3:0] pause_nib;
    logic       meas_start;
    logic       meas_end;
    logic       pause_end;
    logic       count_ev;
    logic       wrap_ev;
    logic       rd_req;

    gpec_evt_if evt ();

    assign hreadyout      = hreadyout_q;
    assign hresp          = hresp_q;
    assign hrdata         = hrdata_q;
    assign gate_out       = gate_out_q;
    assign count_done_irq = done_irq_q;
    assign wrap_irq       = wrap_irq_q;
    assign wake_req       = wake_q;

    // ------------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ------------------------------------------------------------------
    assign rd_req  = hsel && hready && (htrans == gpec_pkg::HTRANS_NONSEQ) && !hwrite;
    assign ctrl_wr = wr_pend_q && (addr_q == gpec_pkg::OFS_CTRL);
    assign tim_wr  = wr_pend_q && (addr_q == gpec_pkg::OFS_TIM);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q   <= 1'b0;
            addr_q      <= 8'h00;
            hreadyout_q <= 1'b1;
            hresp_q     <= gpec_pkg::HRESP_OKAY;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q     <= gpec_pkg::HRESP_OKAY;
            if (hready) begin
                wr_pend_q <= hsel && (htrans == gpec_pkg::HTRANS_NONSEQ) && hwrite;
                addr_q    <= haddr[7:0];
            end
        end
    end

    // read data is fetched in the address phase so it can leave a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_req) begin
            case (haddr[7:0])
                gpec_pkg::OFS_CTRL:  hrdata_q <= {24'h00_0000, count_enable_q, done_irq_enable_q,
                                                  wrap_irq_enable_q, done_flag_q, wrap_flag_q,
                                                  3'h0};
                gpec_pkg::OFS_TIM:   hrdata_q <= {24'h00_0000, timing_q};
                gpec_pkg::OFS_RES_H: hrdata_q <= {24'h00_0000, count_q[15:8]};
                gpec_pkg::OFS_RES_L: hrdata_q <= {24'h00_0000, count_q[7:0]};
                default:             hrdata_q <= 32'h0000_0000;
            endcase
        end else begin
            hrdata_q <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // control and timing registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_enable_q    <= 1'b0;
            done_irq_enable_q <= 1'b0;
            wrap_irq_enable_q <= 1'b0;
        end else if (ctrl_wr) begin
            count_enable_q    <= hwdata[gpec_pkg::BIT_CEN];
            done_irq_enable_q <= hwdata[gpec_pkg::BIT_DIE];
            wrap_irq_enable_q <= hwdata[gpec_pkg::BIT_WIE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timing_q <= gpec_pkg::TIM_RST;
        end else if (tim_wr) begin
            timing_q <= hwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // gate sequencer
    // ------------------------------------------------------------------
    assign run       = count_enable_q && !stop_mode;
    assign gate_int  = (state_q == gpec_pkg::ST_MEAS);
    assign meas_nib  = timing_q[gpec_pkg::MEAS_LSB +: 4];
    assign pause_nib = timing_q[gpec_pkg::PAUSE_LSB +: 4];
    assign unit_last = (unit_q == gpec_pkg::UNIT_W'(UNIT_CYCLES - 1));
    // nibble zero ends its phase at once: a one-cycle gate, or a one-cycle pause
    assign pause_end = (pause_nib == 4'h0) || (unit_last && (step_q == pause_nib - 4'h1));
    assign meas_start = run && !tim_wr &&
                        ((state_q == gpec_pkg::ST_IDLE) ||
                         ((state_q == gpec_pkg::ST_ARM) && (arm_q == 2'h0)) ||
                         ((state_q == gpec_pkg::ST_PAUSE) && pause_end));
    assign meas_end  = run && !tim_wr && gate_int &&
                       ((meas_nib == 4'h0) || (unit_last && (step_q == meas_nib - 4'h1)));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= gpec_pkg::ST_IDLE;
            arm_q   <= 2'h0;
        end else if (!run) begin
            state_q <= gpec_pkg::ST_IDLE;
        end else if (tim_wr) begin
            state_q <= gpec_pkg::ST_ARM;
            arm_q   <= gpec_pkg::ARM_LAST;
        end else begin
            case (state_q)
                gpec_pkg::ST_IDLE:  state_q <= gpec_pkg::ST_MEAS;
                gpec_pkg::ST_ARM: begin
                    if (arm_q == 2'h0) begin
                        state_q <= gpec_pkg::ST_MEAS;
                    end else begin
                        arm_q <= arm_q - 2'h1;
                    end
                end
                gpec_pkg::ST_MEAS: begin
                    if (meas_end) begin
                        state_q <= gpec_pkg::ST_PAUSE;
                    end
                end
                gpec_pkg::ST_PAUSE: begin
                    if (pause_end) begin
                        state_q <= gpec_pkg::ST_MEAS;
                    end
                end
                default: state_q <= gpec_pkg::ST_IDLE;
            endcase
        end
    end

    // unit and step timers restart on every phase change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unit_q <= '0;
            step_q <= 4'h0;
        end else if (!run || tim_wr || meas_start || meas_end ||
                     !(gate_int || (state_q == gpec_pkg::ST_PAUSE))) begin
            unit_q <= '0;
            step_q <= 4'h0;
        end else if (unit_last) begin
            unit_q <= '0;
            step_q <= step_q + 4'h1;
        end else begin
            unit_q <= unit_q + gpec_pkg::UNIT_W'(1);
        end
    end

    // external gate trails the internal one by two cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_d1_q  <= 1'b0;
            gate_out_q <= 1'b0;
        end else begin
            gate_d1_q  <= gate_int;
            gate_out_q <= gate_d1_q;
        end
    end

    // ------------------------------------------------------------------
    // pulse input path
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= pulse_input_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign evt.gated_in = pin_s2_q && gate_int;

    gpec_spike_filter u_filter (
        .hclk    (hclk),
        .hresetn (hresetn),
        .evt     (evt)
    );

    // events trailing the gate through the filter are dropped so the
    // result stays frozen once the window closes
    assign count_ev = evt.event_p && gate_int && !tim_wr && run;
    assign wrap_ev  = count_ev && (count_q == gpec_pkg::COUNT_MAX);

    // ------------------------------------------------------------------
    // event count and flags
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= gpec_pkg::COUNT_ZERO;
        end else if (meas_start) begin
            count_q <= gpec_pkg::COUNT_ZERO;
        end else if (count_ev) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // hardware set wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_flag_q <= 1'b0;
        end else if (meas_end) begin
            done_flag_q <= 1'b1;
        end else if (meas_start) begin
            done_flag_q <= 1'b0;
        end else if (ctrl_wr && hwdata[gpec_pkg::BIT_DCLR]) begin
            done_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wrap_flag_q <= 1'b0;
        end else if (wrap_ev) begin
            wrap_flag_q <= 1'b1;
        end else if (meas_start) begin
            wrap_flag_q <= 1'b0;
        end else if (ctrl_wr && hwdata[gpec_pkg::BIT_WCLR]) begin
            wrap_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // interrupt requests and wakeup
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_irq_q <= 1'b0;
            wrap_irq_q <= 1'b0;
            wake_q     <= 1'b0;
        end else begin
            done_irq_q <= done_flag_q && done_irq_enable_q;
            wrap_irq_q <= wrap_flag_q && wrap_irq_enable_q;
            wake_q     <= (done_flag_q && done_irq_enable_q) ||
                          (wrap_flag_q && wrap_irq_enable_q);
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_wrap_sets_flag: assert property (wrap_ev |=> wrap_flag_q && (count_q == gpec_pkg::COUNT_ZERO))
        else $error("wrap did not set flag or restart count from zero");
    a_done_at_fall: assert property (meas_end |=> done_flag_q && !gate_int)
        else $error("done flag not set when gate fell");
    a_start_clears: assert property (meas_start |=> gate_int && !done_flag_q && !wrap_flag_q
                                     && (count_q == gpec_pkg::COUNT_ZERO))
        else $error("measurement start did not clear count and flags");
    a_ext_gate_lag: assert property ($rose(gate_int) |=> !gate_out_q ##1 gate_out_q)
        else $error("external gate not two cycles behind internal gate");
    a_write_restart: assert property ((tim_wr && (hwdata[3:0] != 4'h0)) ##1 run [*2]
                                      |=> gate_int && (count_q == gpec_pkg::COUNT_ZERO))
        else $error("timing write did not restart the gate on time");
    a_hold_when_low: assert property ((!gate_int && !meas_start) |=> $stable(count_q))
        else $error("result changed while gate was low");
    a_stop_no_gate: assert property (stop_mode |=> !gate_int ##2 !gate_out_q)
        else $error("gate active during stop mode");
    a_done_clear: assert property ((ctrl_wr && hwdata[gpec_pkg::BIT_DCLR] && !meas_end)
                                   |=> !done_flag_q)
        else $error("done clear strobe did not clear flag");
    a_wrap_clear: assert property ((ctrl_wr && hwdata[gpec_pkg::BIT_WCLR] && !wrap_ev)
                                   |=> !wrap_flag_q)
        else $error("wrap clear strobe did not clear flag");
    a_irq_gating: assert property ((!wrap_irq_enable_q || !wrap_flag_q) |=> !wrap_irq_q)
        else $error("wrap interrupt without flag and enable");
    a_done_irq: assert property ((done_flag_q && done_irq_enable_q) |=> count_done_irq && wake_req)
        else $error("enabled done flag raised no interrupt or wakeup");
    a_pause_restart: assert property ((state_q == gpec_pkg::ST_PAUSE) && pause_end && run && !tim_wr
                                      |=> gate_int)
        else $error("gate did not rise after pause expired");
    a_strobe_zero: assert property ((addr_q == gpec_pkg::OFS_CTRL)
                                    |-> (hrdata_q[gpec_pkg::BIT_DCLR:0] == 3'h0))
        else $error("strobe or reserved bits read non-zero");
endmodule
`default_nettype wire

// ---- gpec_pulse_src.sv ----
/* pulse source model for the event pin.
   assumes start is held one cycle while idle. */
`timescale 1ns/10ps
`default_nettype none
module gpec_pulse_src (
    input  wire logic       clk,    // bus clock
    input  wire logic       start,  // begin a burst
    input  wire logic [7:0] n,      // pulse count
    input  wire logic [2:0] w,      // high cycles
    output logic            pin,    // pulse out
    output logic            busy    // burst running
);
    initial begin
        pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (start) begin
                busy <= 1'b1;
                repeat (n) begin
                    pin <= 1'b1;
                    repeat (w) @(posedge clk);
                    pin <= 1'b0;
                    repeat (4) @(posedge clk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- gated_pulse_event_counter_tb.sv ----
/* bench for the gated pulse event counter.
   assumes a 16-cycle gate unit and the pulse model. */
`timescale 1ns/10ps
`default_nettype none
module gated_pulse_event_counter_tb;
    logic        hclk, hresetn, hsel, hwrite, stop_mode, hready, gate, dirq, wake, pin, start, busy, resp, wirq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [7:0]  n;
    logic [2:0]  w;
    int          n_errors, checks_done;
    gpec_counter #(.UNIT_CYCLES(16)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(resp), .hrdata(hrdata), .pulse_input_pin(pin), .stop_mode(stop_mode), .gate_out(gate),
        .count_done_irq(dirq), .wrap_irq(wirq), .wake_req(wake));
    gpec_pulse_src SRC (.clk(hclk), .start(start), .n(n), .w(w), .pin(pin), .busy(busy));
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // ------------------------
    // bus and check tasks
    // ------------------------
    task automatic close_out();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("BAD %0t got %h exp %h", $time, got, exp);
            n_errors++;
        end
    endtask
    // bounded wait: 0 ready, 1 gate, 2 pulse model busy
    task automatic till(input int s, input logic v);
        int i;
        for (i = 0; i < 600; i++) begin
            @(posedge hclk);
            if ((s == 0 ? hready : s == 1 ? gate : busy) === v) return;
        end
        $display("BAD %0t timeout", $time);
        n_errors++;
        close_out();
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        hsel   <= 1'b1;
        htrans <= gpec_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        haddr  <= {24'h00_0000, a};
        till(0, 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        till(0, 1'b1);
        rd = hrdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        xfer(1'b0, a, 8'h00);
        chk(rd[15:0], e);
    endtask
    task automatic burst(input logic [2:0] wid, input logic [7:0] cnt);
        start <= 1'b1;
        w     <= wid;
        n     <= cnt;
        @(posedge hclk);
        start <= 1'b0;
        till(2, 1'b1);
        till(2, 1'b0);
    endtask
    // ------------------------
    // scenarios
    // ------------------------
    task automatic t_regs();
        rc(gpec_pkg::OFS_CTRL, 16'h0000);
        rc(8'h10, 16'h0000);
        xfer(1'b1, gpec_pkg::OFS_TIM, 8'hFF);
        rc(gpec_pkg::OFS_TIM, 16'h00FF);
        chk(gate, 1'b0);
    endtask
    task automatic t_count();
        xfer(1'b1, gpec_pkg::OFS_CTRL, 8'hC0);
        till(1, 1'b1);
        burst(3'h4, 8'h0A);
        burst(3'h2, 8'h03);
        till(1, 1'b0);
        burst(3'h4, 8'h05);
        rc(gpec_pkg::OFS_CTRL, 16'h00D0);
        chk({dirq, wake}, 2'h3);
        chk({resp, wirq}, 2'h0);
        rc(gpec_pkg::OFS_RES_H, 16'h0000);
        rc(gpec_pkg::OFS_RES_L, 16'h000A);
    endtask
    task automatic t_flags();
        till(1, 1'b1);
        rc(gpec_pkg::OFS_CTRL, 16'h00C0);
        rc(gpec_pkg::OFS_RES_L, 16'h0000);
        till(1, 1'b0);
        xfer(1'b1, gpec_pkg::OFS_CTRL, 8'hC4);
        rc(gpec_pkg::OFS_CTRL, 16'h00C0);
        chk(dirq, 1'b0);
        xfer(1'b1, gpec_pkg::OFS_CTRL, 8'hC2);
        rc(gpec_pkg::OFS_CTRL, 16'h00C0);
        xfer(1'b1, gpec_pkg::OFS_TIM, 8'hFF);
        repeat (5) @(posedge hclk);
        chk(gate, 1'b1);
        till(1, 1'b1);
        stop_mode <= 1'b1;
        repeat (8) @(posedge hclk);
        chk(gate, 1'b0);
    endtask
    initial begin
        {hresetn, hsel, hwrite, stop_mode, start} = 5'h00;
        {haddr, hwdata, htrans, n, w} = '0;
        n_errors = 0;
        checks_done = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_count();
        t_flags();
        close_out();
    end
endmodule
`default_nettype wire
